// ===== genset_field_model.sv
// Sensor switches on the engine side of the generator panel
`timescale 1ns/1ps
`default_nettype none

module genset_field_model (
  // Switch states set by the bench
  input  wire logic [4:0] sw_closed,
  input  wire logic       charge_high,
  input  wire logic       volt_closed,
  // Pin levels seen by the panel
  output logic [4:0]      fault_pins,
  output logic            charge_pin,
  output logic            volt_pin
);
  // An open switch to ground leaves the panel pull-up in control
  assign fault_pins = ~sw_closed;
  assign charge_pin = charge_high;
  // Open-collector contact: released means pulled high
  assign volt_pin   = ~volt_closed;
endmodule

`default_nettype wire

// ===== genset_panel_fault_and_relay_logic.sv
// Generator panel: fault qualification, relay drive, indicators and APB registers
//
// Summary of operation
// - Lube pressure fault declared after 1 s.
// - Output fault and stator qualified 100 ms.
// - Polarity select: 1-2 closed OK, 2-3 open OK.
// - Fuel pump on only without enabled shutdown fault.
// - Start button overrides faults for fuel pump.
// - Preheat follows preheat button while crank link is off.
// - Crank link also drives preheat on start.
// - Starter active only while start pressed.
// - Leak severity: red shutdown or yellow warning.
// - Output fault severity: red shutdown or yellow.
// - Fuel level use: yellow, never shutdown.
// - Same input as oil overtemperature fault.
// - Excitation with fuel pump, panel-on, or never; only in 12 V mode.
// - Charge input OK low or high by select.
// - Output voltage OK while contact closed.
// - Red indicator shows each shutdown fault.
// - Coolant switch qualified 100 ms.
// - Water leak qualified 100 ms.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module genset_panel_fault_and_relay_logic
  import genset_panel_pkg::*;
#(
  parameter int unsigned TICK_LEN    = TICK_CYCLES,
  parameter int unsigned SHORT_COUNT = SHORT_TICKS,
  parameter int unsigned LONG_COUNT  = LONG_TICKS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Operator push-buttons, high while pressed
  input  wire logic        preheat_button,
  input  wire logic        start_button,
  // Sensor pins, high when the switch to ground is open
  input  wire logic        coolant_in,
  input  wire logic        leak_in,
  input  wire logic        lube_in,
  input  wire logic        generator_output_fault_in,
  input  wire logic        stator_in,
  input  wire logic        charge_status_in,
  input  wire logic        output_voltage_ok_in,
  // Relays and indicators
  output relay_type        relay,
  output led_type          led,
  // Interrupt
  output logic             irq
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (TICK_LEN < 2) begin : g_bad_tick
    $error("TICK_LEN must be at least 2");
  end
  if (SHORT_COUNT < 1 || LONG_COUNT < SHORT_COUNT) begin : g_bad_count
    $error("delay counts must satisfy 1 <= SHORT_COUNT <= LONG_COUNT");
  end

  localparam int unsigned TW = $clog2(TICK_LEN);
  localparam int unsigned CW = $clog2(LONG_COUNT + 1);

  function automatic logic [CW-1:0] to_count(input int unsigned value);
    return value[CW-1:0];
  endfunction

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  config_type             config_reg;
  logic [EVENT_COUNT-1:0] irq_status_reg;
  logic [EVENT_COUNT-1:0] irq_enable_reg;
  logic [TW-1:0]          tick_count_reg;
  logic                   tick_reg;
  logic [CW-1:0]          qual_count_reg [FAULT_COUNT];
  logic [FAULT_COUNT-1:0] fault_reg;
  logic                   charge_fail_reg;
  logic                   voltage_fail_reg;

  // ---------------------------------------------------------------
  // System tick
  // ---------------------------------------------------------------
  // One shared prescaler keeps every delay counter narrow; its phase
  // against an input edge adds up to one tick of uncertainty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count_reg <= '0;
      tick_reg       <= 1'b0;
    end else if (tick_count_reg == TW'(TICK_LEN - 1)) begin
      tick_count_reg <= '0;
      tick_reg       <= 1'b1;
    end else begin
      tick_count_reg <= tick_count_reg + 1'b1;
      tick_reg       <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Raw fault levels after polarity selection
  // ---------------------------------------------------------------
  logic [FAULT_COUNT-1:0] pin_level;
  logic [FAULT_COUNT-1:0] raw_fault;
  logic [CW-1:0]          qual_limit [FAULT_COUNT];

  assign pin_level[COOLANT_IDX]  = coolant_in;
  assign pin_level[LEAK_IDX]     = leak_in;
  assign pin_level[LUBE_IDX]     = lube_in;
  assign pin_level[OUTFAULT_IDX] = generator_output_fault_in;
  assign pin_level[STATOR_IDX]   = stator_in;

  // A closed switch pulls the pin low; normally closed faults on high
  assign raw_fault = pin_level ^ config_reg.polarity_select;

  always_comb begin
    for (int i = 0; i < FAULT_COUNT; i++) begin
      qual_limit[i] = to_count(SHORT_COUNT);
    end
    qual_limit[LUBE_IDX] = to_count(LONG_COUNT);
  end

  // ---------------------------------------------------------------
  // Fault qualification
  // ---------------------------------------------------------------
  // Only the onset is delayed; a fault clears as soon as the pin recovers
  // The first tick may come right after the onset, so a fault qualifies
  // after between limit-1 and limit tick periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < FAULT_COUNT; i++) begin
        qual_count_reg[i] <= '0;
      end
      fault_reg <= '0;
    end else begin
      for (int i = 0; i < FAULT_COUNT; i++) begin
        if (!raw_fault[i]) begin
          qual_count_reg[i] <= '0;
          fault_reg[i]      <= 1'b0;
        end else if (qual_count_reg[i] >= qual_limit[i]) begin
          fault_reg[i] <= 1'b1;
        end else if (tick_reg) begin
          qual_count_reg[i] <= qual_count_reg[i] + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Charge and output voltage status
  // ---------------------------------------------------------------
  logic charge_fail;
  logic voltage_fail;

  // Select 0 expects a healthy charge signal low, select 1 expects it high
  assign charge_fail  = charge_status_in ^ config_reg.charge_sense_select;
  // A released contact reads high through the pull-up, which means not OK
  assign voltage_fail = output_voltage_ok_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_fail_reg  <= 1'b0;
      voltage_fail_reg <= 1'b0;
    end else begin
      charge_fail_reg  <= charge_fail;
      voltage_fail_reg <= voltage_fail;
    end
  end

  // ---------------------------------------------------------------
  // Severity decode
  // ---------------------------------------------------------------
  logic outfault_is_fault;
  logic outfault_warns;
  logic leak_warns;
  logic [FAULT_COUNT-1:0] shutdown_fault;
  logic                   any_shutdown;

  // Oil overtemperature always stops the engine; fuel level only warns
  assign leak_warns = config_reg.leak_severity_select;
  always_comb begin
    case (config_reg.outfault_use)
      USE_OUTPUT_FAULT: begin
        outfault_is_fault = 1'b1;
        outfault_warns    = config_reg.outfault_severity_select;
      end
      USE_FUEL_LEVEL: begin
        outfault_is_fault = 1'b1;
        outfault_warns    = 1'b1;
      end
      USE_OIL_TEMP: begin
        outfault_is_fault = 1'b1;
        outfault_warns    = 1'b0;
      end
      default: begin
        outfault_is_fault = 1'b0;
        outfault_warns    = 1'b1;
      end
    endcase
  end

  always_comb begin
    shutdown_fault               = fault_reg;
    shutdown_fault[LEAK_IDX]     = fault_reg[LEAK_IDX] & ~leak_warns;
    shutdown_fault[OUTFAULT_IDX] = fault_reg[OUTFAULT_IDX] & outfault_is_fault
                                   & ~outfault_warns;
  end

  assign any_shutdown = |shutdown_fault;

  // ---------------------------------------------------------------
  // Relay drive
  // ---------------------------------------------------------------
  logic fuel_pump_next;
  logic excitation_next;

  // Start button masks fault evaluation so the engine can be cranked
  assign fuel_pump_next = start_button | ~any_shutdown;

  always_comb begin
    case (config_reg.excitation_source_select)
      EXCITE_FUEL_PUMP: excitation_next = fuel_pump_next;
      EXCITE_PANEL_ON:  excitation_next = config_reg.panel_on;
      // Open and the unused fourth code leave the dynamo unexcited
      default:          excitation_next = 1'b0;
    endcase
    // Excitation resistor only exists in the 12 V build
    excitation_next = excitation_next & config_reg.twelve_volt_mode;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay <= '0;
    end else begin
      relay.preheat    <= preheat_button
                          | (config_reg.preheat_with_crank_link & start_button);
      relay.fuel_pump  <= fuel_pump_next;
      relay.starter    <= start_button;
      relay.excitation <= excitation_next;
    end
  end

  // ---------------------------------------------------------------
  // Indicators
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led <= '0;
    end else begin
      led.fault_red       <= shutdown_fault;
      led.leak_yellow     <= fault_reg[LEAK_IDX] & leak_warns;
      // An ignored input lights nothing
      led.outfault_yellow <= fault_reg[OUTFAULT_IDX] & outfault_is_fault
                             & outfault_warns;
      led.charge_red      <= charge_fail_reg;
      led.charge_green    <= ~charge_fail_reg;
      led.voltage_red     <= voltage_fail_reg;
      led.voltage_green   <= ~voltage_fail_reg;
    end
  end

  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------
  logic [EVENT_COUNT-1:0] event_level;
  logic [EVENT_COUNT-1:0] event_level_reg;
  logic [EVENT_COUNT-1:0] event_pulse;

  assign event_level = {voltage_fail_reg, charge_fail_reg, fault_reg};
  // Only the rise of a level raises an event, so a standing fault does
  // not set again a status bit that software has cleared
  assign event_pulse = event_level & ~event_level_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_level_reg <= '0;
    end else begin
      event_level_reg <= event_level;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic access;
  logic write_strobe;
  logic addr_mapped;
  logic [31:0] read_value;

  // One wait state: pready rises on the second access cycle
  assign access       = psel & penable;
  assign write_strobe = access & pready & pwrite;

  // Write decode shared by every writable offset
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] offset);
    return strobe && (addr == offset);
  endfunction

  // Unmapped offsets answer with an error and read as zero
  always_comb begin
    addr_mapped = 1'b1;
    read_value  = 32'h0000_0000;
    case (paddr)
      CONFIG_OFFSET:     read_value = 32'(config_reg);
      STATE_OFFSET:      read_value = {16'h0000, 4'h0, relay, 1'b0, voltage_fail_reg,
                                       charge_fail_reg, fault_reg};
      IRQ_STATUS_OFFSET: read_value = 32'(irq_status_reg);
      IRQ_CLEAR_OFFSET:  read_value = 32'h0000_0000;
      IRQ_ENABLE_OFFSET: read_value = 32'(irq_enable_reg);
      default:           addr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~addr_mapped;
      prdata  <= (access & ~pready & ~pwrite) ? read_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg     <= config_type'(CONFIG_RESET);
      irq_enable_reg <= IRQ_ENABLE_RESET;
    end else begin
      if (reg_hit(write_strobe, paddr, CONFIG_OFFSET)) begin
        config_reg <= config_type'(pwdata[CONFIG_WIDTH-1:0]);
      end
      if (reg_hit(write_strobe, paddr, IRQ_ENABLE_OFFSET)) begin
        irq_enable_reg <= pwdata[EVENT_COUNT-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  logic [EVENT_COUNT-1:0] clear_mask;

  assign clear_mask = reg_hit(write_strobe, paddr, IRQ_CLEAR_OFFSET) ?
                      pwdata[EVENT_COUNT-1:0] : '0;

  // A new event in the clearing cycle stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~clear_mask) | event_pulse;
      irq            <= |(((irq_status_reg & ~clear_mask) | event_pulse) & irq_enable_reg);
    end
  end

endmodule

`default_nettype wire

// ===== genset_panel_fault_and_relay_logic_bench.sv
// Self-checking bench for the generator panel fault and relay logic
`timescale 1ns/1ps
`default_nettype none

module genset_panel_fault_and_relay_logic_bench import genset_panel_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, charge_pin, volt_pin;
  logic        preheat_button = 1'b0, start_button = 1'b0;
  logic [4:0]  sw_closed = 5'h1F, fault_pins;
  logic        charge_high = 1'b0, volt_closed = 1'b1;
  relay_type   relay;
  led_type     led;
  logic [10:0] led_bits;
  int          n_errors = 0, checks_done = 0;

  assign led_bits = led;
  always #12.5 pclk = ~pclk;

  genset_field_model field (.sw_closed(sw_closed), .charge_high(charge_high),
    .volt_closed(volt_closed), .fault_pins(fault_pins), .charge_pin(charge_pin),
    .volt_pin(volt_pin));

  // Short counts keep the run brief: 4-cycle tick, 3 and 6 ticks
  genset_panel_fault_and_relay_logic #(.TICK_LEN(4), .SHORT_COUNT(3), .LONG_COUNT(6)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .preheat_button(preheat_button), .start_button(start_button),
    .coolant_in(fault_pins[0]), .leak_in(fault_pins[1]), .lube_in(fault_pins[2]),
    .generator_output_fault_in(fault_pins[3]), .stator_in(fault_pins[4]),
    .charge_status_in(charge_pin), .output_voltage_ok_in(volt_pin),
    .relay(relay), .led(led), .irq(irq));

  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Values read right after an edge are those settled before it
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(rd, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  function automatic logic [31:0] rl();
    return {28'h0, relay};
  endfunction

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    chk(rl(), 32'h4);
    rd_chk(CONFIG_OFFSET, 32'h0, 1'b0);
    rd_chk(8'h14, 32'h0, 1'b1);
    rd_chk(IRQ_CLEAR_OFFSET, 32'h0, 1'b0);
    wr(CONFIG_OFFSET, 32'hFFFF_FFFF);
    rd_chk(CONFIG_OFFSET, 32'h7FFF, 1'b0);
    wr(CONFIG_OFFSET, 32'h0);
    settle(3);
    chk({28'h0, led_bits[3:0]}, 32'h5);
    charge_high <= 1'b1;
    volt_closed <= 1'b0;
    settle(3);
    chk({28'h0, led_bits[3:0]}, 32'hA);
    wr(CONFIG_OFFSET, 32'h1000);
    settle(3);
    chk({28'h0, led_bits[3:0]}, 32'h6);
    charge_high <= 1'b0;
    volt_closed <= 1'b1;
    wr(CONFIG_OFFSET, 32'h0);
    for (int i = 0; i < 5; i++) begin
      sw_closed[i] <= 1'b0;
      settle(i == 2 ? 20 : 10);
      chk({27'h0, led_bits[10:6]}, 32'h0);
      settle(25);
      chk({27'h0, led_bits[10:6]}, 32'h1 << i);
      chk(rl(), 32'h0);
      sw_closed[i] <= 1'b1;
      settle(4);
      chk(rl(), 32'h4);
    end
    sw_closed[0] <= 1'b0;
    settle(6);
    sw_closed[0] <= 1'b1;
    settle(1);
    sw_closed[0] <= 1'b0;
    settle(10);
    chk({27'h0, led_bits[10:6]}, 32'h0);
    sw_closed <= 5'h00;
    wr(CONFIG_OFFSET, 32'h001F);
    sw_closed[4] <= 1'b1;
    settle(35);
    chk({27'h0, led_bits[10:6]}, 32'h10);
    sw_closed <= 5'h15;
    wr(CONFIG_OFFSET, 32'h0060);
    settle(35);
    chk({21'h0, led_bits}, 32'h35);
    chk(rl(), 32'h4);
    sw_closed[1] <= 1'b1;
    wr(CONFIG_OFFSET, 32'h0080);
    settle(35);
    chk({21'h0, led_bits}, 32'h15);
    chk(rl(), 32'h4);
    wr(CONFIG_OFFSET, 32'h0100);
    settle(35);
    chk({27'h0, led_bits[10:6]}, 32'h8);
    chk(rl(), 32'h0);
    wr(CONFIG_OFFSET, 32'h0180);
    settle(3);
    chk({21'h0, led_bits}, 32'h5);
    chk(rl(), 32'h4);
    sw_closed <= 5'h1E;
    wr(CONFIG_OFFSET, 32'h0200);
    settle(35);
    start_button <= 1'b1;
    settle(2);
    chk(rl(), 32'hE);
    start_button <= 1'b0;
    preheat_button <= 1'b1;
    settle(2);
    chk(rl(), 32'h8);
    preheat_button <= 1'b0;
    wr(CONFIG_OFFSET, 32'h0);
    start_button <= 1'b1;
    settle(2);
    chk(rl(), 32'h6);
    start_button <= 1'b0;
    sw_closed <= 5'h1F;
    wr(CONFIG_OFFSET, 32'h2400);
    settle(4);
    chk(rl(), 32'h5);
    sw_closed[0] <= 1'b0;
    settle(35);
    chk(rl(), 32'h0);
    sw_closed[0] <= 1'b1;
    wr(CONFIG_OFFSET, 32'h6800);
    settle(4);
    chk(rl(), 32'h5);
    wr(CONFIG_OFFSET, 32'h4800);
    settle(3);
    chk(rl(), 32'h4);
    wr(CONFIG_OFFSET, 32'h0);
    wr(IRQ_CLEAR_OFFSET, 32'h7F);
    wr(IRQ_ENABLE_OFFSET, 32'h01);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    sw_closed[0] <= 1'b0;
    settle(35);
    chk({31'h0, irq}, 32'h1);
    rd_chk(IRQ_STATUS_OFFSET, 32'h01, 1'b0);
    wr(IRQ_ENABLE_OFFSET, 32'h0);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    wr(IRQ_ENABLE_OFFSET, 32'h01);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    wr(IRQ_CLEAR_OFFSET, 32'h01);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    rd_chk(IRQ_STATUS_OFFSET, 32'h0, 1'b0);
    end_sim();
  end
endmodule

`default_nettype wire

// ===== genset_panel_pkg.sv
// Constants and types shared by the generator panel fault and relay logic
package genset_panel_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned SHORT_DELAY_MS = 100;
  localparam int unsigned LONG_DELAY_MS  = 1000;
  localparam int unsigned SHORT_TICKS    = SHORT_DELAY_MS * 1000 / TICK_US;
  localparam int unsigned LONG_TICKS     = LONG_DELAY_MS * 1000 / TICK_US;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CONFIG_OFFSET     = 8'h00;
  localparam logic [7:0] STATE_OFFSET      = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h10;

  localparam int unsigned CONFIG_WIDTH = 15;
  localparam logic [CONFIG_WIDTH-1:0] CONFIG_RESET = 15'h0000;
  localparam int unsigned EVENT_COUNT = 7;
  localparam logic [EVENT_COUNT-1:0] IRQ_ENABLE_RESET = 7'h00;

  // Fault input index
  localparam int unsigned FAULT_COUNT     = 5;
  localparam int unsigned COOLANT_IDX     = 0;
  localparam int unsigned LEAK_IDX        = 1;
  localparam int unsigned LUBE_IDX        = 2;
  localparam int unsigned OUTFAULT_IDX    = 3;
  localparam int unsigned STATOR_IDX      = 4;
  localparam int unsigned CHARGE_EVT_IDX  = 5;
  localparam int unsigned VOLTAGE_EVT_IDX = 6;

  // Uses of the generator output fault input
  typedef enum logic [1:0] {
    USE_OUTPUT_FAULT = 2'h0,
    USE_FUEL_LEVEL   = 2'h1,
    USE_OIL_TEMP     = 2'h2
  } outfault_use_type;

  // Dynamo excitation source
  typedef enum logic [1:0] {
    EXCITE_OPEN      = 2'h0,
    EXCITE_FUEL_PUMP = 2'h1,
    EXCITE_PANEL_ON  = 2'h2
  } excite_type;

  // Polarity bits: 0 = jumper 1-2 (normally closed), 1 = 2-3 (normally open).
  // Severity bits: 0 = jumper 1-2 (red, shutdown), 1 = 2-3 (yellow, warning).
  typedef struct packed {
    logic             panel_on;
    logic             twelve_volt_mode;
    logic             charge_sense_select;
    excite_type       excitation_source_select;
    logic             preheat_with_crank_link;
    outfault_use_type outfault_use;
    logic             outfault_severity_select;
    logic             leak_severity_select;
    logic [FAULT_COUNT-1:0] polarity_select;
  } config_type;

  typedef struct packed {
    logic [FAULT_COUNT-1:0] fault_red;
    logic                   leak_yellow;
    logic                   outfault_yellow;
    logic                   charge_red;
    logic                   charge_green;
    logic                   voltage_red;
    logic                   voltage_green;
  } led_type;

  typedef struct packed {
    logic preheat;
    logic fuel_pump;
    logic starter;
    logic excitation;
  } relay_type;

endpackage

// ===== genset_panel_properties.sv
// Concurrent checks on the generator panel ports
`timescale 1ns/1ps
`default_nettype none

module genset_panel_checker
  import genset_panel_pkg::*;
#(
  parameter int unsigned TICK_LEN    = TICK_CYCLES,
  parameter int unsigned SHORT_COUNT = SHORT_TICKS,
  parameter int unsigned LONG_COUNT  = LONG_TICKS
) (
  // Clock and reset
  input wire logic      pclk,
  input wire logic      presetn,
  // APB handshake
  input wire logic      psel,
  input wire logic      penable,
  input wire logic      pready,
  // Buttons and sensor pins
  input wire logic      preheat_button,
  input wire logic      start_button,
  input wire logic      coolant_in,
  input wire logic      leak_in,
  input wire logic      lube_in,
  input wire logic      generator_output_fault_in,
  input wire logic      stator_in,
  // Outputs under watch
  input wire relay_type relay,
  input wire led_type   led
);
  // The first tick may follow the onset at once, so one tick period is slack
  localparam int unsigned SHORT_MIN = (SHORT_COUNT - 1) * TICK_LEN;
  localparam int unsigned LONG_MIN  = (LONG_COUNT - 1) * TICK_LEN;
  logic [4:0]  pins;
  logic [4:0]  pins_prev;
  logic [31:0] still_cnt [5];

  assign pins = {stator_in, generator_output_fault_in, lube_in, leak_in, coolant_in};

  // Cycles since each pin last moved; a short glitch must never qualify
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        still_cnt[i] <= 32'h0000_0000;
      end
    end else begin
      pins_prev <= pins;
      for (int i = 0; i < 5; i++) begin
        if (pins[i] != pins_prev[i]) begin
          still_cnt[i] <= 32'h0000_0000;
        end else if (still_cnt[i] != 32'hFFFF_FFFF) begin
          still_cnt[i] <= still_cnt[i] + 32'h0000_0001;
        end
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_wait_s;
    psel && penable && !pready;
  endsequence

  apb_ready_a: assert property (apb_wait_s |=> pready)
    else $error("pready missing after wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  starter_on_a: assert property (start_button |=> relay.starter)
    else $error("starter not driven while start pressed");
  starter_off_a: assert property (!start_button |=> !relay.starter)
    else $error("starter driven without start");
  fuel_override_a: assert property (start_button |=> relay.fuel_pump)
    else $error("fuel pump off while start pressed");
  preheat_hold_a: assert property (preheat_button |=> relay.preheat)
    else $error("preheat off while button held");
  preheat_idle_a: assert property (!preheat_button && !start_button |=> !relay.preheat)
    else $error("preheat on with no button");
  coolant_delay_a: assert property ($rose(led.fault_red[0]) |-> still_cnt[0] >= SHORT_MIN)
    else $error("coolant fault shown too early");
  leak_delay_a: assert property ($rose(led.fault_red[1]) |-> still_cnt[1] >= SHORT_MIN)
    else $error("leak fault shown too early");
  lube_delay_a: assert property ($rose(led.fault_red[2]) |-> still_cnt[2] >= LONG_MIN)
    else $error("lube fault shown too early");
  outfault_delay_a: assert property ($rose(led.fault_red[3]) |-> still_cnt[3] >= SHORT_MIN)
    else $error("output fault shown too early");
  stator_delay_a: assert property ($rose(led.fault_red[4]) |-> still_cnt[4] >= SHORT_MIN)
    else $error("stator fault shown too early");
endmodule

bind genset_panel_fault_and_relay_logic genset_panel_checker #(
  .TICK_LEN(TICK_LEN), .SHORT_COUNT(SHORT_COUNT), .LONG_COUNT(LONG_COUNT)
) checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .preheat_button(preheat_button), .start_button(start_button), .coolant_in(coolant_in),
  .leak_in(leak_in), .lube_in(lube_in), .generator_output_fault_in(generator_output_fault_in),
  .stator_in(stator_in), .relay(relay), .led(led)
);

`default_nettype wire
